/* File: common/capture_pkg.sv */
// capture sequencer package: register map, field layout, constants
// assumes a 32-bit ahb-lite slave with word-aligned registers
package capture_pkg;

  // printed offsets are not all multiples of four: index times four
  localparam logic [11:0] count_index    = 12'h54c;
  localparam logic [11:0] control_index  = 12'h54e;
  localparam logic [13:0] count_addr     = {count_index, 2'b00};
  localparam logic [13:0] control_addr   = {control_index, 2'b00};
  localparam logic [13:0] preset_addr    = 14'h1540;
  localparam logic [13:0] cmp_last_addr  = 14'h1544;
  localparam logic [13:0] status_addr    = 14'h1548;
  localparam logic [13:0] cmp_ctrl_addr  = 14'h154c;

  localparam logic [15:0] count_reset    = 16'h0000;
  localparam logic [15:0] control_reset  = 16'h0000;
  localparam logic [15:0] control_mask   = 16'hf13f;
  localparam logic [15:0] count_one      = 16'h0001;
  localparam logic [15:0] count_zero     = 16'h0000;
  localparam logic [31:0] word_zero      = 32'h0000_0000;
  localparam logic [5:0]  index_zero     = 6'h00;
  localparam logic [5:0]  index_one      = 6'h01;
  localparam logic [6:0]  motion_cmd     = 7'h32;

  localparam int unsigned start_bit      = 0;
  localparam int unsigned preset_bit     = 1;
  localparam int unsigned cmp_arm_bit    = 2;
  localparam int unsigned launch_bit     = 3;
  localparam int unsigned src_lsb        = 4;
  localparam int unsigned pol_bit        = 8;
  localparam int unsigned time_lsb       = 12;

  localparam logic [1:0] src_disabled    = 2'h0;
  localparam logic [1:0] src_reserved    = 2'h1;
  localparam logic [1:0] src_pulse       = 2'h2;
  localparam logic [1:0] src_encoder     = 2'h3;

  localparam logic [1:0] htrans_nonseq   = 2'h2;
  localparam logic [2:0] hsize_word      = 3'h2;

  typedef struct packed {
    logic [3:0]  trig_time_ms;
    logic [2:0]  unused_hi;
    logic        polarity;
    logic [1:0]  unused_mid;
    logic [1:0]  source;
    logic        launch;
    logic        cmp_arm;
    logic        preset;
    logic        start;
  } control_type;

  typedef struct packed {
    logic [31:0] position;
    logic [5:0]  index;
  } capture_word_type;

endpackage : capture_pkg

/* File: core/trigger_qualify.sv */
// trigger qualifier: polarity and edge detect of the capture input
// assumes trig_in synchronous to hclk
`timescale 1ns/1ps
module trigger_qualify
  import capture_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic trig_in,
  input  wire logic normally_closed,
  input  wire logic enable,
  output logic      fire
);
  logic level_reg;
  logic level_next;
  logic active;

  // normally closed contact reads active when the line drops
  always_comb begin
    active     = trig_in ^ normally_closed;
    level_next = active;
    fire       = enable && active && !level_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_reg <= 1'b1;
    end else begin
      level_reg <= level_next;
    end
  end
endmodule : trigger_qualify

/* File: core/position_capture_control.sv */
// position capture sequencer with ahb-lite register slave
// assumes one clock, triggers and positions synchronous to hclk
//
// Summary of operation
// - start with count nonzero arms, clears done
// - each capture decrements remaining count
// - count zero: done high, start cleared
// - start with zero count: no arm, clear
// - start written while set: a zero disarms, a one does not re-arm
// - preset option loads position after first capture
// - compare option sets compare start, loads count
// - compare option ignored if compare enabled
// - launch option fires motion command fifty
// - count writable while compare disabled
// - control word 16 bits, masked to f13f
// - source field picks disabled, pulse, encoder
// - polarity: normally open or closed input
// - trigger time field in milliseconds
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module position_capture_control
  import capture_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        trig_in,
  input  wire logic [31:0] pulse_position,
  input  wire logic [31:0] encoder_position,
  input  wire logic        compare_enabled,
  output logic             capture_done_output,
  output logic             position_load,
  output logic [31:0]      position_load_value,
  output logic             compare_start,
  output logic [15:0]      compare_count_load,
  output logic             motion_start,
  output logic [6:0]       motion_index,
  output logic             capture_write,
  output logic [37:0]      capture_word,
  output logic [3:0]       trig_time_ms
);

  logic [15:0]      count_reg, count_next;
  control_type      ctrl_reg, ctrl_next;
  logic [31:0]      preset_reg, preset_next;
  logic [15:0]      cmp_last_reg, cmp_last_next;
  logic             done_reg, done_next;
  logic             first_reg, first_next;
  logic [5:0]       index_reg, index_next;
  logic             pload_reg, pload_next;
  logic             cstart_reg, cstart_next;
  logic             motion_reg, motion_next;
  logic             cwrite_reg, cwrite_next;
  capture_word_type cword_reg, cword_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             wr_pend_reg, wr_pend_next;
  logic [13:0]      addr_reg, addr_next;

  logic        fire;
  logic [31:0] src_position;
  logic        src_valid;
  logic [15:0] wval;
  logic        wr_ctrl;
  control_type wctrl;

  trigger_qualify u_trig (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .trig_in         (trig_in),
    .normally_closed (ctrl_reg.polarity),
    .enable          (ctrl_reg.start && src_valid),
    .fire            (fire)
  );

  // reserved source value captures nothing, same as disabled
  always_comb begin
    src_valid    = 1'b0;
    src_position = word_zero;
    case (ctrl_reg.source)
      src_pulse: begin
        src_valid    = 1'b1;
        src_position = pulse_position;
      end
      src_encoder: begin
        src_valid    = 1'b1;
        src_position = encoder_position;
      end
      default: begin
        src_valid    = 1'b0;
        src_position = word_zero;
      end
    endcase
  end

  // bus: address phase registered, write applied in data phase
  always_comb begin
    addr_next    = addr_reg;
    wr_pend_next = 1'b0;
    if (hsel && hready && htrans[1]) begin
      addr_next    = haddr[13:0];
      wr_pend_next = hwrite;
    end
  end

  always_comb begin
    wval    = hwdata[15:0];
    wr_ctrl = wr_pend_reg && (addr_reg == control_addr);
    wctrl   = control_type'(wval & control_mask);
  end

  always_comb begin
    count_next    = count_reg;
    ctrl_next     = ctrl_reg;
    preset_next   = preset_reg;
    cmp_last_next = cmp_last_reg;
    done_next     = done_reg;
    first_next    = first_reg;
    index_next    = index_reg;
    pload_next    = 1'b0;
    cstart_next   = 1'b0;
    motion_next   = 1'b0;
    cwrite_next   = 1'b0;
    cword_next    = cword_reg;

    if (wr_pend_reg) begin
      case (addr_reg)
        count_addr: begin
          if (!compare_enabled) begin
            count_next = wval;
          end
        end
        preset_addr:   preset_next   = hwdata;
        cmp_last_addr: cmp_last_next = wval;
        default: begin
        end
      endcase
    end

    if (wr_ctrl) begin
      ctrl_next = wctrl;
      if (ctrl_reg.start) begin
        // once armed the written start bit lands as is, but a one does not re-arm
        ctrl_next.start = 1'b0;
        if (wctrl.start) begin
          ctrl_next.start = 1'b1;
        end
      end else if (wctrl.start) begin
        done_next = 1'b0;
        if (count_reg == count_zero) begin
          ctrl_next.start = 1'b0;
        end else begin
          ctrl_next.start = 1'b1;
          first_next      = 1'b1;
          index_next      = index_zero;
        end
      end
    end

    // a capture in the write cycle still counts: hardware wins
    if (fire && count_reg != count_zero) begin
      cwrite_next = 1'b1;
      cword_next  = '{position: src_position, index: index_reg};
      index_next  = index_reg + index_one;
      count_next  = count_reg - count_one;
      first_next  = 1'b0;
      if (first_reg) begin
        if (ctrl_reg.preset) begin
          pload_next = 1'b1;
        end
        if (ctrl_reg.cmp_arm && !compare_enabled) begin
          cstart_next = 1'b1;
        end
      end
      if (count_reg == count_one) begin
        done_next       = 1'b1;
        ctrl_next.start = 1'b0;
        if (ctrl_reg.launch) begin
          motion_next = 1'b1;
        end
      end
    end
  end

  always_comb begin
    rdata_next = word_zero;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[13:0])
        count_addr:    rdata_next = {16'h0000, count_reg};
        control_addr:  rdata_next = {16'h0000, ctrl_reg};
        preset_addr:   rdata_next = preset_reg;
        cmp_last_addr: rdata_next = {16'h0000, cmp_last_reg};
        status_addr:   rdata_next = {26'h0000000, index_reg};
        cmp_ctrl_addr: rdata_next = {31'h00000000, done_reg};
        default:       rdata_next = word_zero;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg    <= count_reset;
      ctrl_reg     <= control_type'(control_reset);
      preset_reg   <= word_zero;
      cmp_last_reg <= count_zero;
      done_reg     <= 1'b0;
      first_reg    <= 1'b0;
      index_reg    <= index_zero;
      pload_reg    <= 1'b0;
      cstart_reg   <= 1'b0;
      motion_reg   <= 1'b0;
      cwrite_reg   <= 1'b0;
      cword_reg    <= '0;
      rdata_reg    <= word_zero;
      wr_pend_reg  <= 1'b0;
      addr_reg     <= 14'h0000;
    end else begin
      count_reg    <= count_next;
      ctrl_reg     <= ctrl_next;
      preset_reg   <= preset_next;
      cmp_last_reg <= cmp_last_next;
      done_reg     <= done_next;
      first_reg    <= first_next;
      index_reg    <= index_next;
      pload_reg    <= pload_next;
      cstart_reg   <= cstart_next;
      motion_reg   <= motion_next;
      cwrite_reg   <= cwrite_next;
      cword_reg    <= cword_next;
      rdata_reg    <= rdata_next;
      wr_pend_reg  <= wr_pend_next;
      addr_reg     <= addr_next;
    end
  end

  always_comb begin
    hrdata              = rdata_reg;
    hreadyout           = 1'b1;
    hresp               = 1'b0;
    capture_done_output = done_reg;
    position_load       = pload_reg;
    position_load_value = preset_reg;
    compare_start       = cstart_reg;
    compare_count_load  = cmp_last_reg;
    motion_start        = motion_reg;
    motion_index        = motion_cmd;
    capture_write       = cwrite_reg;
    capture_word        = cword_reg;
    trig_time_ms        = ctrl_reg.trig_time_ms;
  end

  sequence s_last_capture;
    fire && count_reg == count_one;
  endsequence

  sequence s_done_cleared;
    capture_done_output && !ctrl_reg.start;
  endsequence

  a_done_on_last: assert property (@(posedge hclk) disable iff (!hresetn)
    s_last_capture |=> s_done_cleared)
    else $error("done not set after last capture");

  a_count_decrement: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (fire && count_reg != count_zero)
    |=> count_reg == $past(count_reg) - count_one)
    else $error("count did not drop by one");

  a_arm_clears_done: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_ctrl && !ctrl_reg.start && wctrl.start && count_reg != count_zero
     && !fire) |=> ctrl_reg.start && !capture_done_output)
    else $error("start did not arm");

  a_zero_no_arm: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_ctrl && !ctrl_reg.start && count_reg == count_zero)
    |=> !ctrl_reg.start)
    else $error("armed with zero count");

  a_store_before_dec: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (count_reg != $past(count_reg))
    |-> (capture_write || $past(wr_pend_reg)))
    else $error("count moved without a store");

  a_cmp_suppressed: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (fire && compare_enabled) |=> !compare_start)
    else $error("compare armed while enabled");

  a_launch_motion: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (fire && count_reg == count_one && ctrl_reg.launch) |=> motion_start)
    else $error("motion command not launched");

  a_control_masked: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ctrl_reg & ~control_mask) == count_zero)
    else $error("control word holds bits outside mask");

  a_count_locked: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_pend_reg && addr_reg == count_addr && compare_enabled && !fire)
    |=> $stable(count_reg))
    else $error("count written while compare enabled");

  sequence s_first_capture;
    fire && count_reg != count_zero && first_reg;
  endsequence

  a_zero_clears_done: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_ctrl && !ctrl_reg.start && wctrl.start && count_reg == count_zero)
    |=> !capture_done_output)
    else $error("done kept on start with zero count");

  a_rearm_rejected: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_ctrl && ctrl_reg.start && wctrl.start && !fire)
    |=> ctrl_reg.start && $stable(index_reg) && $stable(first_reg))
    else $error("armed start bit was written again");

  a_preset_first: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_first_capture ##0 ctrl_reg.preset
    |=> position_load)
    else $error("position not preset after first capture");

  a_cmp_arm_first: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_first_capture ##0 (ctrl_reg.cmp_arm && !compare_enabled)
    |=> compare_start)
    else $error("compare not started after first capture");

  a_source_gate: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ctrl_reg.source == src_disabled || ctrl_reg.source == src_reserved)
    |=> !capture_write)
    else $error("capture taken with source disabled");

endmodule : position_capture_control

/* File: verification/capture_source_model.sv */
// far side: capture trigger contact and the two position sources
// assumes fire_req is a one-cycle request from the bench
`timescale 1ns/1ps
module capture_source_model #(
  parameter logic [31:0] enc_value   = 32'h0000_0000,
  parameter logic [31:0] pulse_value = 32'h0000_0000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        fire_req,
  input  wire logic        normally_closed,
  output logic             trig_in,
  output logic [31:0]      pulse_position,
  output logic [31:0]      encoder_position
);
  logic [1:0] hold_reg;

  // contact stays active three cycles so exactly one edge is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_reg <= 2'h0;
    else if (fire_req)
      hold_reg <= 2'h3;
    else if (hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
  end

  // idle level follows the contact type
  assign trig_in          = (hold_reg != 2'h0) ^ normally_closed;
  assign pulse_position   = pulse_value;
  assign encoder_position = enc_value;
endmodule : capture_source_model

/* File: verification/testbench.sv */
// self-checking bench of the capture sequencer over ahb-lite
// assumes zero-wait slave, pulses registered one edge after trigger
`timescale 1ns/1ps
module testbench
  import capture_pkg::*;
;
  localparam logic [31:0] enc_value   = 32'h00c0_ffee;
  localparam logic [31:0] pulse_value = 32'h0bad_0001;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, fire_req, normally_closed;
  logic        compare_enabled;
  logic [31:0] haddr, hwdata, hrdata, pulse_position, encoder_position;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, trig_in, capture_done_output;
  logic        position_load, compare_start, motion_start, capture_write;
  logic [31:0] position_load_value;
  logic [15:0] compare_count_load;
  logic [6:0]  motion_index;
  logic [37:0] capture_word;
  logic [3:0]  trig_time_ms;
  logic [7:0]  n_cw = 8'h0, n_pl = 8'h0, n_cs = 8'h0, n_ms = 8'h0;
  logic [37:0] last_word = 38'h0;
  logic [31:0] last_load = 32'h0;
  logic [15:0] last_cmp = 16'h0;
  logic [6:0]  last_motion = 7'h0;
  int          n_mismatch = 0;
  int          n_checks = 0;

  always #5 hclk = ~hclk;

  position_capture_control position_capture_control_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .trig_in(trig_in), .pulse_position(pulse_position),
    .encoder_position(encoder_position),
    .compare_enabled(compare_enabled),
    .capture_done_output(capture_done_output),
    .position_load(position_load),
    .position_load_value(position_load_value),
    .compare_start(compare_start),
    .compare_count_load(compare_count_load),
    .motion_start(motion_start), .motion_index(motion_index),
    .capture_write(capture_write), .capture_word(capture_word),
    .trig_time_ms(trig_time_ms));

  capture_source_model #(.enc_value(enc_value),
                         .pulse_value(pulse_value)) capture_source_model_inst (
    .hclk(hclk), .hresetn(hresetn), .fire_req(fire_req),
    .normally_closed(normally_closed), .trig_in(trig_in),
    .pulse_position(pulse_position), .encoder_position(encoder_position));

  // one-cycle pulses are counted and their payload kept
  always @(posedge hclk) begin
    if (capture_write === 1'b1) begin
      n_cw <= n_cw + 8'h1;
      last_word <= capture_word;
    end
    if (position_load === 1'b1) begin
      n_pl <= n_pl + 8'h1;
      last_load <= position_load_value;
    end
    if (compare_start === 1'b1) begin
      n_cs <= n_cs + 8'h1;
      last_cmp <= compare_count_load;
    end
    if (motion_start === 1'b1) begin
      n_ms <= n_ms + 8'h1;
      last_motion <= motion_index;
    end
  end

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [13:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {18'h0, a};
    htrans <= htrans_nonseq;
    hwrite <= w;
    hsize <= hsize_word;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    // the write lands at the data phase edge: look one edge later
    @(posedge hclk);
  endtask : wr

  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, word_zero, x);
    check(x, e);
  endtask : rd_chk

  task automatic fire();
    fire_req <= 1'b1;
    @(posedge hclk);
    fire_req <= 1'b0;
    // short on purpose: a capture on the wrong contact edge comes too late
    repeat (3) @(posedge hclk);
  endtask : fire

  task automatic s_reset();
    rd_chk(count_addr, 32'h0);
    rd_chk(control_addr, 32'h0);
    rd_chk(14'h1ffc, 32'h0);
    check(hreadyout, 1'b1);
    check(hresp, 1'b0);
    check(capture_done_output, 1'b0);
  endtask : s_reset

  task automatic s_count_rw();
    wr(count_addr, 32'h5);
    rd_chk(count_addr, 32'h5);
    compare_enabled <= 1'b1;
    wr(count_addr, 32'h9);
    rd_chk(count_addr, 32'h5);
    compare_enabled <= 1'b0;
  endtask : s_count_rw

  task automatic s_zero_start();
    wr(count_addr, 32'h0);
    wr(control_addr, 32'h31);
    rd_chk(control_addr, 32'h30);
    check(capture_done_output, 1'b0);
    fire();
    check(n_cw, 8'h0);
  endtask : s_zero_start

  task automatic s_full_seq();
    wr(preset_addr, 32'h1234_5678);
    wr(cmp_last_addr, 32'h0000_abcd);
    wr(count_addr, 32'h2);
    wr(control_addr, 32'h3f);
    rd_chk(control_addr, 32'h3f);
    fire();
    check(n_cw, 8'h1);
    rd_chk(count_addr, 32'h1);
    check(last_word, {enc_value, index_zero});
    check(n_pl, 8'h1);
    check(last_load, 32'h1234_5678);
    check(n_cs, 8'h1);
    check(last_cmp, 16'habcd);
    wr(control_addr, 32'h3f);
    fire();
    check(last_word, {enc_value, index_one});
    rd_chk(count_addr, 32'h0);
    check(capture_done_output, 1'b1);
    rd_chk(control_addr, 32'h3e);
    check(n_pl, 8'h1);
    check(n_ms, 8'h1);
    check(last_motion, 7'h32);
    wr(control_addr, 32'h31);
    check(capture_done_output, 1'b0);
    rd_chk(control_addr, 32'h30);
  endtask : s_full_seq

  task automatic s_cmp_ignored();
    wr(count_addr, 32'h1);
    compare_enabled <= 1'b1;
    wr(control_addr, 32'h25);
    fire();
    check(n_cs, 8'h1);
    check(last_word, {pulse_value, index_zero});
    compare_enabled <= 1'b0;
  endtask : s_cmp_ignored

  task automatic s_disarm();
    wr(count_addr, 32'h3);
    wr(control_addr, 32'h31);
    check(capture_done_output, 1'b0);
    wr(control_addr, 32'h30);
    fire();
    check(n_cw, 8'h3);
    rd_chk(count_addr, 32'h3);
  endtask : s_disarm

  task automatic s_fields();
    normally_closed <= 1'b1;
    wr(count_addr, 32'h1);
    wr(control_addr, 32'h131);
    fire();
    check(n_cw, 8'h4);
    wr(count_addr, 32'h1);
    wr(control_addr, 32'h101);
    fire();
    check(n_cw, 8'h4);
    wr(control_addr, 32'h0);
    wr(control_addr, 32'h111);
    fire();
    check(n_cw, 8'h4);
    wr(control_addr, 32'h0);
    wr(control_addr, 32'hfffe);
    rd_chk(control_addr, 32'hf13e);
    check(trig_time_ms, 4'hf);
  endtask : s_fields

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = hsize_word;
    hwdata = 32'h0;
    fire_req = 1'b0;
    normally_closed = 1'b0;
    compare_enabled = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_count_rw();
    s_zero_start();
    s_full_seq();
    s_cmp_ignored();
    s_disarm();
    s_fields();
    complete_run();
  end
endmodule : testbench
